// file: sfs_pkg.sv
package sfs_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] SFS_CTRL_OFS = 8'h00;
  localparam logic [7:0] SFS_DELAY_OFS = 8'h04;
  localparam logic [7:0] SFS_STAT_OFS = 8'h08;
  localparam logic [7:0] SFS_ISR_OFS = 8'h0c;
  localparam logic [7:0] SFS_IMR_OFS = 8'h10;
  localparam logic [7:0] SFS_REMAIN_OFS = 8'h14;
  localparam logic [7:0] SFS_EST_OFS = 8'h18;
  // control fields
  localparam int SFS_CTRL_SW_EN_BIT = 0;
  localparam int SFS_CTRL_DLY_EN_BIT = 1;
  localparam int SFS_CTRL_FLY_BIT = 2;
  // event fields, shared by status and mask
  localparam int SFS_EV_SWITCH_BIT = 0;
  localparam int SFS_EV_RAMP_BIT = 1;
  // reset values
  localparam logic [2:0] SFS_CTRL_RST = 3'h0;
  localparam logic [14:0] SFS_DELAY_RST = 15'h0000;
  localparam logic [1:0] SFS_IMR_RST = 2'h0;
  // ------------------------------------------------------------
  // timing and thresholds
  // ------------------------------------------------------------
  localparam int SFS_CLK_PERIOD_NS = 100;
  localparam int SFS_MS_NS = 1000000;
  localparam int SFS_MS_CYCLES = SFS_MS_NS / SFS_CLK_PERIOD_NS;
  localparam logic [14:0] SFS_DELAY_MAX_MS = 15'h7530;
  localparam logic [6:0] SFS_CONV_MS = 7'h64;
  localparam logic [16:0] SFS_FAIL_RPM = 17'h0012c;
  localparam logic [15:0] SFS_THRESH_RPM = 16'h012c;
  localparam logic [4:0] SFS_PCT_NUM = 5'h13;
  localparam logic [4:0] SFS_PCT_DEN = 5'h14;
  localparam int SFS_EST_SHIFT = 3;
  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0]
  {
    SFS_IDLE = 3'b001,
    SFS_HOLD = 3'b010,
    SFS_RUN = 3'b100
  } sfs_seq_type;
endpackage

// file: sfs_speed_estimator.sv
`timescale 1ns/1ns
`default_nettype none
module sfs_speed_estimator
  import sfs_pkg::*;
#(
  parameter int W = 16,
  parameter int SHIFT = SFS_EST_SHIFT
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic signed [W-1:0] model_speed,
  output logic signed [W-1:0] est_speed
);
  logic signed [W-1:0] est_r;
  logic signed [W-1:0] est_nxt;
  logic signed [W:0] err;

  // first-order tracker; runs every cycle whatever feedback is in use
  always_comb
  begin
    err = {model_speed[W-1], model_speed} - {est_r[W-1], est_r};
    est_nxt = est_r + W'(err >>> SHIFT);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      est_r <= '0;
    else
      est_r <= est_nxt;
  end

  assign est_speed = est_r;
endmodule
`default_nettype wire

// file: sfs_switchover.sv
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sfs_switchover
  import sfs_pkg::*;
#(
  parameter int MS_CYCLES = SFS_MS_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_cmd,
  input wire logic autotune_active,
  input wire logic signed [15:0] encoder_speed,
  input wire logic signed [15:0] model_speed,
  input wire logic signed [15:0] speed_setpoint,
  output logic signed [15:0] feedback_speed,
  output logic sensorless,
  output logic ramp_enable,
  output logic switchover_warning,
  output logic irq
);
  localparam int TW = $clog2(MS_CYCLES + 1);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [14:0] delay_r, delay_nxt;
  logic [1:0] isr_r, isr_nxt;
  logic [1:0] imr_r, imr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  sfs_seq_type st_r, st_nxt;
  logic [14:0] remain_r, remain_nxt;
  logic [TW-1:0] tick_r, tick_nxt;
  logic [6:0] conv_r, conv_nxt;
  logic reached_r, reached_nxt;
  logic [15:0] sp0_r, sp0_nxt;
  logic sensorless_r, sensorless_nxt;
  logic signed [15:0] fb_r, fb_nxt;
  logic signed [15:0] est_speed;
  logic wr_acc, rd_setup, mapped, ms_tick, conv_done, low_sp;
  logic fail, sw_allowed, switch_evt, ramp_evt;
  logic [16:0] diff, diff_abs;
  logic [15:0] est_abs, sp_abs;

  // ------------------------------------------------------------
  // estimator, always running alongside the encoder
  // ------------------------------------------------------------
  sfs_speed_estimator #(.W(16), .SHIFT(SFS_EST_SHIFT)) u_est
  (
    .pclk(pclk),
    .presetn(presetn),
    .model_speed(model_speed),
    .est_speed(est_speed)
  );

  // ------------------------------------------------------------
  // speed comparisons
  // ------------------------------------------------------------
  // 17-bit difference so that -32768 cannot wrap
  always_comb
  begin
    diff = {encoder_speed[15], encoder_speed} - {est_speed[15], est_speed};
    diff_abs = diff[16] ? 17'(-diff) : diff;
    fail = diff_abs > SFS_FAIL_RPM;
    est_abs = est_speed[15] ? 16'(-est_speed) : est_speed;
    sp_abs = speed_setpoint[15] ? 16'(-speed_setpoint) : speed_setpoint;
    low_sp = sp_abs < SFS_THRESH_RPM;
    conv_done = conv_r == SFS_CONV_MS;
    ms_tick = tick_r == TW'(MS_CYCLES - 1);
    sw_allowed = ctrl_r[SFS_CTRL_SW_EN_BIT]
      && !autotune_active && !ctrl_r[SFS_CTRL_FLY_BIT]
      && conv_done
      && reached_r
      && !low_sp
      && st_r == SFS_RUN && run_cmd;
    switch_evt = sw_allowed && fail && !sensorless_r;
  end

  // ------------------------------------------------------------
  // sequencer, start delay and switchover latch
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    remain_nxt = remain_r;
    tick_nxt = ms_tick ? '0 : tick_r + TW'(1);
    conv_nxt = conv_r;
    reached_nxt = reached_r;
    sp0_nxt = sp0_r;
    sensorless_nxt = sensorless_r;
    ramp_evt = 1'b0;
    unique case (st_r)
      SFS_IDLE:
      begin
        tick_nxt = '0;
        if (run_cmd)
        begin
          sp0_nxt = sp_abs;
          conv_nxt = '0;
          reached_nxt = 1'b0;
          if (ctrl_r[SFS_CTRL_DLY_EN_BIT] && delay_r != '0)
          begin
            st_nxt = SFS_HOLD;
            remain_nxt = delay_r;
          end
          else
          begin
            st_nxt = SFS_RUN;
            ramp_evt = 1'b1;
          end
        end
      end
      SFS_HOLD:
      begin
        if (!run_cmd)
        begin
          st_nxt = SFS_IDLE;
          remain_nxt = '0;
        end
        else if (ms_tick)
        begin
          remain_nxt = remain_r - 15'h0001;
          if (remain_r == 15'h0001)
          begin
            st_nxt = SFS_RUN;
            ramp_evt = 1'b1;
          end
        end
      end
      SFS_RUN:
      begin
        if (ms_tick && !conv_done)
          conv_nxt = conv_r + 7'h01;
        // 95% test: |est| * 20 >= |sp0| * 19, kept once reached
        if (21'(est_abs) * 21'(SFS_PCT_DEN) >= 21'(sp0_r) * 21'(SFS_PCT_NUM))
          reached_nxt = 1'b1;
        if (switch_evt)
          sensorless_nxt = 1'b1;
        if (!run_cmd)
        begin
          st_nxt = SFS_IDLE;
          sensorless_nxt = 1'b0;
        end
      end
    endcase
    // feedback mux, registered; no way back to encoder while latched
    fb_nxt = (sensorless_r || switch_evt) ? est_speed : encoder_speed;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= SFS_IDLE;
      remain_r <= '0;
      tick_r <= '0;
      conv_r <= '0;
      reached_r <= 1'b0;
      sp0_r <= '0;
      sensorless_r <= 1'b0;
      fb_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      remain_r <= remain_nxt;
      tick_r <= tick_nxt;
      conv_r <= conv_nxt;
      reached_r <= reached_nxt;
      sp0_r <= sp0_nxt;
      sensorless_r <= sensorless_nxt;
      fb_r <= fb_nxt;
    end
  end

  // ------------------------------------------------------------
  // apb slave: zero wait, read data captured in setup phase
  // ------------------------------------------------------------
  always_comb
  begin
    wr_acc = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;
    mapped = paddr inside {SFS_CTRL_OFS, SFS_DELAY_OFS, SFS_STAT_OFS,
      SFS_ISR_OFS, SFS_IMR_OFS, SFS_REMAIN_OFS, SFS_EST_OFS};
    ctrl_nxt = ctrl_r;
    delay_nxt = delay_r;
    imr_nxt = imr_r;
    isr_nxt = isr_r;
    prdata_nxt = prdata_r;
    if (wr_acc && paddr == SFS_CTRL_OFS)
      ctrl_nxt = pwdata[2:0];
    // settings beyond 30 s are clamped
    if (wr_acc && paddr == SFS_DELAY_OFS)
      delay_nxt = (pwdata[31:15] != '0 || pwdata[14:0] > SFS_DELAY_MAX_MS)
        ? SFS_DELAY_MAX_MS : pwdata[14:0];
    if (wr_acc && paddr == SFS_IMR_OFS)
      imr_nxt = pwdata[1:0];
    // write one to clear; a new event in the same cycle wins
    if (wr_acc && paddr == SFS_ISR_OFS)
      isr_nxt = isr_r & ~pwdata[1:0];
    if (switch_evt)
      isr_nxt[SFS_EV_SWITCH_BIT] = 1'b1;
    if (ramp_evt)
      isr_nxt[SFS_EV_RAMP_BIT] = 1'b1;
    if (rd_setup)
    begin
      unique case (paddr)
        SFS_CTRL_OFS: prdata_nxt = {29'h0, ctrl_r};
        SFS_DELAY_OFS: prdata_nxt = {17'h0, delay_r};
        SFS_STAT_OFS: prdata_nxt = {26'h0, reached_r, conv_done, st_r, sensorless_r};
        SFS_ISR_OFS: prdata_nxt = {30'h0, isr_r};
        SFS_IMR_OFS: prdata_nxt = {30'h0, imr_r};
        SFS_REMAIN_OFS: prdata_nxt = {17'h0, remain_r};
        SFS_EST_OFS: prdata_nxt = {{16{est_speed[15]}}, est_speed};
        default: prdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= SFS_CTRL_RST;
      delay_r <= SFS_DELAY_RST;
      isr_r <= '0;
      imr_r <= SFS_IMR_RST;
      prdata_r <= '0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      delay_r <= delay_nxt;
      isr_r <= isr_nxt;
      imr_r <= imr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign feedback_speed = fb_r;
  assign sensorless = sensorless_r;
  assign switchover_warning = isr_r[SFS_EV_SWITCH_BIT];
  assign ramp_enable = st_r == SFS_RUN;
  assign irq = |(isr_r & imr_r);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_delayed_start;
    st_r == SFS_IDLE && run_cmd && ctrl_r[SFS_CTRL_DLY_EN_BIT] && delay_r != '0;
  endsequence

  sequence s_blocked;
    !sensorless_r && (autotune_active || ctrl_r[SFS_CTRL_FLY_BIT]);
  endsequence

  a_switch_disabled: assert property (!ctrl_r[SFS_CTRL_SW_EN_BIT] && !sensorless_r
    |=> !sensorless_r) else $error("switchover while disabled");
  a_switch_on_fail: assert property (sw_allowed && diff_abs > SFS_FAIL_RPM
    |=> sensorless_r && feedback_speed == $past(est_speed)) else $error("missed switch");
  a_latch_holds: assert property (sensorless_r && run_cmd && st_r == SFS_RUN
    |=> sensorless_r) else $error("sensorless dropped while running");
  a_no_reconnect: assert property (sensorless_r ##1 sensorless_r
    |-> feedback_speed == $past(est_speed)) else $error("encoder reconnected");
  a_warn_raised: assert property ($rose(sensorless_r)
    |-> switchover_warning) else $error("no switchover warning");
  a_tune_block: assert property (s_blocked |=> !sensorless_r)
    else $error("switch during autotune or flycatch");
  a_conv_block: assert property (!conv_done && !sensorless_r
    |=> !sensorless_r) else $error("switch before convergence");
  a_speed_block: assert property (!reached_r && !sensorless_r
    |=> !sensorless_r) else $error("switch below 95 percent");
  a_low_block: assert property (low_sp && !sensorless_r
    |=> !sensorless_r) else $error("switch below threshold");
  a_delay_load: assert property (s_delayed_start
    |=> st_r == SFS_HOLD && !ramp_enable && remain_r == $past(delay_r))
    else $error("start delay not loaded");
  a_remain_step: assert property (st_r == SFS_HOLD && run_cmd && ms_tick
    |=> remain_r == $past(remain_r) - 15'd1) else $error("remaining delay wrong");
  a_stop_clear: assert property (!run_cmd && st_r != SFS_HOLD
    |=> !sensorless_r) else $error("stop kept sensorless");
  a_abs_diff: assert property (sw_allowed && diff_abs <= SFS_FAIL_RPM
    |=> !$rose(sensorless_r)) else $error("switch without discrepancy");
endmodule
`default_nettype wire

// file: sfs_motor_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// motor, encoder and power stage
// ------------------------------------------------------------
module sfs_motor_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ramp_enable,
  input wire logic signed [15:0] speed_setpoint,
  input wire logic signed [15:0] fault_ofs,
  output logic signed [15:0] encoder_speed,
  output logic signed [15:0] model_speed
);
  logic signed [15:0] spd_r;

  // shaft slews 4 rpm a cycle, so the 95% point arrives late on high setpoints
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      spd_r <= 16'sh0000;
    else if (ramp_enable && spd_r < speed_setpoint)
      spd_r <= spd_r + 16'sh0004;
    else if (!ramp_enable && spd_r > 16'sh0000)
      spd_r <= spd_r - 16'sh0004;
  end

  // offset stands for a slipping or miswired sensor
  assign model_speed = spd_r;
  assign encoder_speed = spd_r + fault_ofs;
endmodule
`default_nettype wire

// file: tb_sfs_switchover.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sfs_switchover
  import sfs_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic run_cmd = 1'b0;
  logic autotune_active = 1'b0;
  logic signed [15:0] encoder_speed;
  logic signed [15:0] model_speed;
  logic signed [15:0] speed_setpoint = 16'sh0000;
  logic signed [15:0] fault_ofs = 16'sh0000;
  logic signed [15:0] feedback_speed;
  logic sensorless;
  logic ramp_enable;
  logic switchover_warning;
  logic irq;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int cmp_count = 0;
  int n;

  sfs_switchover #(.MS_CYCLES(10)) i_sfs_switchover (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd),
    .autotune_active(autotune_active), .encoder_speed(encoder_speed),
    .model_speed(model_speed), .speed_setpoint(speed_setpoint),
    .feedback_speed(feedback_speed), .sensorless(sensorless), .ramp_enable(ramp_enable),
    .switchover_warning(switchover_warning), .irq(irq));

  sfs_motor_model i_sfs_motor_model (.pclk(pclk), .presetn(presetn),
    .ramp_enable(ramp_enable), .speed_setpoint(speed_setpoint), .fault_ofs(fault_ofs),
    .encoder_speed(encoder_speed), .model_speed(model_speed));

  // ------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ------------------------------------------------------------
  initial
  begin
    forever #50 pclk = ~pclk;
  end

  // whole run is near 13k cycles; 50k leaves margin
  initial
  begin
    #5000000;
    bad_count++;
    print_verdict();
  end

  task automatic print_verdict();
  begin
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  // stop cycle, then wait for the shaft to come to rest
  task automatic stop_motor();
  begin
    @(posedge pclk);
    run_cmd <= 1'b0;
    fault_ofs <= 16'sh0000;
    autotune_active <= 1'b0;
    n = 0;
    while (model_speed !== 16'sh0000 && n < 9000)
    begin
      @(posedge pclk);
      n++;
    end
    // a shaft that never stops is a hang, not a pass
    if (n >= 9000)
      bad_count++;
    @(posedge pclk);
  end
  endtask

  // start, inject an encoder offset after fdly cycles, sample wt cycles later
  task automatic run_case(input logic [2:0] ctrl, input logic at, input logic [15:0] sp,
                          input logic [15:0] f, input int fdly, input int wt,
                          input logic exp, input logic keep);
  begin
    apb(1'b1, SFS_CTRL_OFS, {29'h0, ctrl}, rd, err);
    @(posedge pclk);
    autotune_active <= at;
    speed_setpoint <= sp;
    run_cmd <= 1'b1;
    repeat (fdly) @(posedge pclk);
    fault_ofs <= f;
    repeat (wt) @(posedge pclk);
    check(sensorless, exp);
    if (!keep)
      stop_motor();
  end
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SFS_CTRL_OFS, 32'h0, rd, err);
    check(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0, rd, err);
    check({rd[0], err}, 2'h1);
    apb(1'b1, SFS_DELAY_OFS, 32'h00009c40, rd, err);
    apb(1'b0, SFS_DELAY_OFS, 32'h0, rd, err);
    check(rd, {17'h0, SFS_DELAY_MAX_MS});
    // start delay of 3 ms, 30 cycles at the shortened tick
    apb(1'b1, SFS_DELAY_OFS, 32'h3, rd, err);
    apb(1'b1, SFS_CTRL_OFS, 32'h2, rd, err);
    @(posedge pclk);
    speed_setpoint <= 16'sh03e8;
    run_cmd <= 1'b1;
    apb(1'b0, SFS_REMAIN_OFS, 32'h0, rd, err);
    check(rd, 32'h3);
    check(ramp_enable, 1'b0);
    n = 0;
    while (ramp_enable !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    check(n >= 24 && n <= 30, 1'b1);
    apb(1'b0, SFS_ISR_OFS, 32'h0, rd, err);
    check(rd[1], 1'b1);
    stop_motor();
    apb(1'b1, SFS_ISR_OFS, 32'h3, rd, err);
    // a stop during the hold aborts the start, no ramp event
    @(posedge pclk);
    run_cmd <= 1'b1;
    repeat (5) @(posedge pclk);
    run_cmd <= 1'b0;
    apb(1'b0, SFS_REMAIN_OFS, 32'h0, rd, err);
    check(rd, 32'h0);
    check(ramp_enable, 1'b0);
    apb(1'b0, SFS_ISR_OFS, 32'h0, rd, err);
    check(rd[1], 1'b0);
    // each blocking condition alone must hold off the switch
    run_case(3'h0, 1'b0, 16'sh03e8, 16'sh0190, 1200, 50, 1'b0, 1'b0);
    run_case(3'h1, 1'b1, 16'sh03e8, 16'sh0190, 1200, 50, 1'b0, 1'b0);
    run_case(3'h5, 1'b0, 16'sh03e8, 16'sh0190, 1200, 50, 1'b0, 1'b0);
    run_case(3'h1, 1'b0, 16'sh00c8, 16'sh0190, 1200, 50, 1'b0, 1'b0);
    run_case(3'h1, 1'b0, 16'sh03e8, 16'sh0190, 300, 400, 1'b0, 1'b0);
    run_case(3'h1, 1'b0, 16'sh7530, 16'sh0190, 1200, 400, 1'b0, 1'b0);
    // encoder reads low: the difference is negative
    apb(1'b1, SFS_IMR_OFS, 32'h1, rd, err);
    apb(1'b0, SFS_IMR_OFS, 32'h0, rd, err);
    check(rd, 32'h1);
    run_case(3'h1, 1'b0, 16'sh03e8, 16'shfe70, 1200, 20, 1'b1, 1'b1);
    check({switchover_warning, irq}, 2'h3);
    check(feedback_speed !== encoder_speed, 1'b1);
    @(posedge pclk);
    fault_ofs <= 16'sh0000;
    repeat (100) @(posedge pclk);
    check(sensorless, 1'b1);
    apb(1'b0, SFS_STAT_OFS, 32'h0, rd, err);
    check(rd[0], 1'b1);
    check(rd[5:1], {2'b11, 3'b100});
    apb(1'b1, SFS_ISR_OFS, 32'h1, rd, err);
    @(posedge pclk);
    check({switchover_warning, irq}, 2'h0);
    stop_motor();
    check(sensorless, 1'b0);
    run_case(3'h1, 1'b0, 16'sh03e8, 16'sh0000, 1200, 20, 1'b0, 1'b1);
    check(feedback_speed, encoder_speed);
    apb(1'b0, SFS_EST_OFS, 32'h0, rd, err);
    n = $signed(rd[15:0]) - model_speed;
    check(n < 8 && n > -8, 1'b1);
    stop_motor();
    print_verdict();
  end
endmodule
`default_nettype wire
